// File: nsp_map.svh
// Purpose: constants of the negative-sequence protection block
// Assumes: 250 MHz clock, 10 ms protection timebase
// Notes: squared quantities carry a x10000 percent-squared scale
`ifndef NSP_MAP_SVH
`define NSP_MAP_SVH
`define NSP_CLK_MHZ 250
`define NSP_TICK_MS 10
`define NSP_TICK_CYC (`NSP_TICK_MS * `NSP_CLK_MHZ * 1000)
`define NSP_TICKS_PER_S (1000 / `NSP_TICK_MS)
`define NSP_PR_DELAY_MS 100
`define NSP_RUN_BLOCK_MS 2000
`define NSP_DEP_CAP_S 1000
`define NSP_SEC_MIN_UA 250000
`define NSP_PR_RATIO_PCT 80
`define NSP_PR_LEVEL_TENTHS 2
`define NSP_PCT2 10000
`define NSP_REL_NUM 231
`define NSP_REL_SH 8
`define NSP_ROT_SIN 18'sh06EDA
`define NSP_ROT_COS 18'sh04000
`define NSP_ROT_SH 15
`define NSP_OV_GROUPS 4
`define NSP_OV_STAGES 3
`endif

// File: nsp_pkg.sv
// Purpose: types shared by the negative-sequence protection block
// Assumes: phasors are signed 16-bit real and imaginary parts
// Notes: none
package nsp_pkg;
  typedef struct packed {
    logic signed [15:0] re;
    logic signed [15:0] im;
  } phasor_t;
  typedef struct packed {
    phasor_t a;
    phasor_t b;
    phasor_t c;
  } tri_t;
  typedef struct packed {
    logic signed [19:0] re;
    logic signed [19:0] im;
  } cplx_t;
  typedef struct packed {
    logic [6:0] pct;
    logic [14:0] dly;
  } ov_set_t;
  typedef struct packed {
    logic trip;
    logic start;
  } stage_out_t;
  typedef enum logic {OC_DEFINITE = 1'b0, OC_DEPENDENT = 1'b1} oc_mode_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_TIMING = 2'b01, ST_TRIPPED = 2'b11} stg_state_t;
endpackage

// File: negative_sequence_protection.sv
// Purpose: broken conductor, neg-seq overcurrent, phase reversal, 3 neg-seq overvoltage
// Assumes: phasor inputs synchronous to clk_i; settings held static
// Notes: state code bit 0 is start, bit 1 is trip
`include "nsp_map.svh"
module negative_sequence_protection #(
  parameter int TICK_CYCLES = `NSP_TICK_CYC,
  parameter int I_LSB_UA = 1000
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire nsp_pkg::tri_t cur_i,
  input wire nsp_pkg::tri_t vol_i,
  input wire logic [15:0] motor_rated_current_i,
  input wire logic [15:0] nominal_voltage_i,
  input wire logic [6:0] bc_pct_i,
  input wire logic [12:0] bc_dly_i,
  input wire logic [6:0] oc_pct_i,
  input wire nsp_pkg::oc_mode_t oc_mode_i,
  input wire logic [12:0] oc_dly_i,
  input wire logic [5:0] delay_multiplier_i,
  input wire logic motor_running_i,
  input wire nsp_pkg::ov_set_t [`NSP_OV_GROUPS-1:0][`NSP_OV_STAGES-1:0] ov_cfg_i,
  input wire logic [1:0] ov_group_i,
  input wire logic [`NSP_OV_STAGES-1:0] ov_block_i,
  output nsp_pkg::stage_out_t bc_o,
  output nsp_pkg::stage_out_t oc_o,
  output nsp_pkg::stage_out_t pr_o,
  output nsp_pkg::stage_out_t [`NSP_OV_STAGES-1:0] ov_o
);
  import nsp_pkg::*;

  localparam int NST = 3 + `NSP_OV_STAGES;
  localparam int BC = 0;
  localparam int OC = 1;
  localparam int PR = 2;
  localparam int OV = 3;
  localparam int DW = $clog2(TICK_CYCLES + 1);
  localparam logic [19:0] PR_TICKS = 20'(`NSP_PR_DELAY_MS / `NSP_TICK_MS);
  localparam logic [7:0] RUN_TICKS = 8'(`NSP_RUN_BLOCK_MS / `NSP_TICK_MS);
  localparam logic [19:0] CAP_TICKS = 20'(`NSP_DEP_CAP_S * `NSP_TICKS_PER_S);
  localparam logic [15:0] SEC_MIN = 16'(`NSP_SEC_MIN_UA / I_LSB_UA);

  ////////////////////////////////////////////////////////////////////////
  // Arithmetic helpers
  function automatic cplx_t widen(phasor_t x);
    cplx_t r;
    r.re = 20'(x.re);
    r.im = 20'(x.im);
    return r;
  endfunction
  // Multiply by a (sq=0) or a squared (sq=1)
  function automatic cplx_t rot(phasor_t x, logic sq);
    logic signed [35:0] sr, si, hr, hi;
    cplx_t r;
    sr = `NSP_ROT_SIN * x.re;
    si = `NSP_ROT_SIN * x.im;
    hr = `NSP_ROT_COS * x.re;
    hi = `NSP_ROT_COS * x.im;
    if (!sq) begin
      r.re = 20'((-hr - si) >>> `NSP_ROT_SH);
      r.im = 20'((sr - hi) >>> `NSP_ROT_SH);
    end else begin
      r.re = 20'((-hr + si) >>> `NSP_ROT_SH);
      r.im = 20'((-sr - hi) >>> `NSP_ROT_SH);
    end
    return r;
  endfunction
  // Three times the positive (neg=0) or negative (neg=1) sequence phasor
  function automatic cplx_t seq3(tri_t p, logic neg);
    cplx_t b, c, r;
    b = rot(p.b, neg);
    c = rot(p.c, !neg);
    r.re = 20'(p.a.re) + b.re + c.re;
    r.im = 20'(p.a.im) + b.im + c.im;
    return r;
  endfunction
  function automatic logic [63:0] mag2(cplx_t z);
    logic signed [39:0] pr, pi;
    pr = z.re * z.re;
    pi = z.im * z.im;
    return 64'(pr) + 64'(pi);
  endfunction
  // Magnitude estimate: max plus 3/8 of min
  function automatic logic [17:0] amag(phasor_t x);
    logic [15:0] ar, ai, mx, mn;
    ar = x.re[15] ? 16'(-x.re) : 16'(x.re);
    ai = x.im[15] ? 16'(-x.im) : 16'(x.im);
    mx = (ar > ai) ? ar : ai;
    mn = (ar > ai) ? ai : ar;
    return 18'(mx) + 18'((18'(mn) * 18'h00003) >> 3);
  endfunction
  function automatic logic [63:0] sq64(logic [15:0] v);
    return 64'(v) * 64'(v);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Timebase
  logic [DW-1:0] div_r, div_nxt;
  logic tick_r, tick_nxt;
  always_comb begin
    tick_nxt = (div_r == DW'(TICK_CYCLES - 1));
    div_nxt = tick_nxt ? '0 : DW'(div_r + 1'b1);
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_r <= '0;
      tick_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Measured quantities
  logic [63:0] i1_c, i2_c, v2_c, imot2_c;
  logic all_min_c, any_lvl_c, avg_lvl_c;
  logic [19:0] amag_sum_c;
  always_comb begin
    i1_c = mag2(seq3(cur_i, 1'b0));
    i2_c = mag2(seq3(cur_i, 1'b1));
    v2_c = mag2(seq3(vol_i, 1'b1));
    imot2_c = sq64(motor_rated_current_i);
    all_min_c = (mag2(widen(cur_i.a)) > sq64(SEC_MIN)) &&
                (mag2(widen(cur_i.b)) > sq64(SEC_MIN)) &&
                (mag2(widen(cur_i.c)) > sq64(SEC_MIN));
    any_lvl_c = (mag2(widen(cur_i.a)) * 64'h64 > imot2_c * 64'h4) ||
                (mag2(widen(cur_i.b)) * 64'h64 > imot2_c * 64'h4) ||
                (mag2(widen(cur_i.c)) * 64'h64 > imot2_c * 64'h4);
    amag_sum_c = 20'(amag(cur_i.a)) + 20'(amag(cur_i.b)) + 20'(amag(cur_i.c));
    avg_lvl_c = (36'(amag_sum_c) * 36'h00000000A) >
                (36'(motor_rated_current_i) * 36'(3 * `NSP_PR_LEVEL_TENTHS));
  end

  ////////////////////////////////////////////////////////////////////////
  // Running time for phase-reversal block
  logic [7:0] run_cnt_r, run_cnt_nxt;
  logic run_blk_c;
  always_comb begin
    run_blk_c = (run_cnt_r >= RUN_TICKS);
    run_cnt_nxt = run_cnt_r;
    if (!motor_running_i) begin
      run_cnt_nxt = '0;
    end else if (tick_r && !run_blk_c) begin
      run_cnt_nxt = run_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run_cnt_r <= '0;
    end else begin
      run_cnt_r <= run_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-stage compare quantities
  logic [63:0] q_c [NST];
  logic [63:0] t_c [NST];
  logic en_c [NST];
  logic [19:0] dly_c [NST];
  logic on_c [NST];
  logic off_c [NST];
  ov_set_t ov_sel_c [`NSP_OV_STAGES];
  stg_state_t st_r [NST];
  stg_state_t st_nxt [NST];
  logic [19:0] cnt_r [NST];
  logic [19:0] cnt_nxt [NST];
  logic expire_c [NST];
  always_comb begin
    q_c[BC] = i2_c * 64'(`NSP_PCT2);
    t_c[BC] = i1_c * 64'(bc_pct_i) * 64'(bc_pct_i);
    en_c[BC] = 1'b1;
    dly_c[BC] = 20'(bc_dly_i) * 20'h0000A;
    q_c[OC] = i2_c * 64'(`NSP_PCT2);
    t_c[OC] = imot2_c * 64'(9) * 64'(oc_pct_i) * 64'(oc_pct_i);
    en_c[OC] = all_min_c;
    dly_c[OC] = 20'(oc_dly_i) * 20'h0000A;
    q_c[PR] = i2_c * 64'(`NSP_PCT2);
    t_c[PR] = i1_c * 64'(`NSP_PR_RATIO_PCT * `NSP_PR_RATIO_PCT);
    en_c[PR] = !run_blk_c && any_lvl_c && avg_lvl_c;
    dly_c[PR] = PR_TICKS;
    for (int s = 0; s < `NSP_OV_STAGES; s++) begin
      ov_sel_c[s] = ov_cfg_i[ov_group_i][s];
      q_c[OV+s] = v2_c * 64'(`NSP_PCT2);
      t_c[OV+s] = sq64(nominal_voltage_i) * 64'(9) *
                  64'(ov_sel_c[s].pct) * 64'(ov_sel_c[s].pct);
      en_c[OV+s] = !ov_block_i[s];
      dly_c[OV+s] = 20'(ov_sel_c[s].dly);
    end
    for (int i = 0; i < NST; i++) begin
      on_c[i] = en_c[i] && (q_c[i] > t_c[i]);
      off_c[i] = !en_c[i] ||
                 ((q_c[i] << `NSP_REL_SH) < t_c[i] * 64'(`NSP_REL_NUM));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Dependent-time integrator
  logic [63:0] acc_r, acc_nxt, inc_c, lim_c;
  always_comb begin
    inc_c = (q_c[OC] > t_c[OC]) ? q_c[OC] - t_c[OC] : '0;
    lim_c = 64'(delay_multiplier_i) * 64'(9 * `NSP_TICKS_PER_S * `NSP_PCT2) * imot2_c;
    acc_nxt = acc_r;
    if (st_r[OC] == ST_IDLE) begin
      acc_nxt = '0;
    end else if (tick_r && st_r[OC] == ST_TIMING && acc_r < lim_c) begin
      acc_nxt = acc_r + inc_c;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc_r <= '0;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stage start/trip sequencers
  always_comb begin
    for (int i = 0; i < NST; i++) begin
      expire_c[i] = (20'(cnt_r[i] + 20'h00001) >= dly_c[i]);
      if (i == OC && oc_mode_i == OC_DEPENDENT) begin
        expire_c[i] = (acc_r + inc_c >= lim_c) ||
                      (20'(cnt_r[i] + 20'h00001) >= CAP_TICKS);
      end
      st_nxt[i] = st_r[i];
      cnt_nxt[i] = cnt_r[i];
      unique case (st_r[i])
        ST_IDLE: begin
          cnt_nxt[i] = '0;
          if (on_c[i]) begin
            st_nxt[i] = ST_TIMING;
          end
        end
        ST_TIMING: begin
          if (off_c[i]) begin
            st_nxt[i] = ST_IDLE;
            cnt_nxt[i] = '0;
          end else if (tick_r) begin
            cnt_nxt[i] = 20'(cnt_r[i] + 20'h00001);
            if (expire_c[i]) begin
              st_nxt[i] = ST_TRIPPED;
            end
          end
        end
        ST_TRIPPED: begin
          if (off_c[i]) begin
            st_nxt[i] = ST_IDLE;
            cnt_nxt[i] = '0;
          end
        end
        default: begin
          st_nxt[i] = ST_IDLE;
          cnt_nxt[i] = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < NST; i++) begin
        st_r[i] <= ST_IDLE;
        cnt_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NST; i++) begin
        st_r[i] <= st_nxt[i];
        cnt_r[i] <= cnt_nxt[i];
      end
    end
  end

  assign bc_o = stage_out_t'(st_r[BC]);
  assign oc_o = stage_out_t'(st_r[OC]);
  assign pr_o = stage_out_t'(st_r[PR]);
  for (genvar s = 0; s < `NSP_OV_STAGES; s++) begin : g_ov
    assign ov_o[s] = stage_out_t'(st_r[OV+s]);
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  bc_trip_delay_a: assert property ($rose(st_r[BC] == ST_TRIPPED) |->
    $past(cnt_r[BC]) + 20'h00001 >= $past(dly_c[BC]) && $past(tick_r))
    else $error("broken conductor tripped early");
  bc_release_a: assert property (st_r[BC] != ST_IDLE && off_c[BC] |=>
    st_r[BC] == ST_IDLE && cnt_r[BC] == '0)
    else $error("broken conductor not released");
  stage_restart_a: assert property (st_r[OV] == ST_IDLE && on_c[OV] |=>
    st_r[OV] == ST_TIMING && cnt_r[OV] == '0)
    else $error("overvoltage count did not restart");
  oc_inhibit_a: assert property (!all_min_c |=> st_r[OC] == ST_IDLE)
    else $error("overcurrent active below minimum current");
  oc_cap_a: assert property (st_r[OC] == ST_TIMING |-> cnt_r[OC] < CAP_TICKS)
    else $error("dependent delay exceeded cap");
  pr_delay_a: assert property ($rose(st_r[PR] == ST_TRIPPED) |->
    $past(cnt_r[PR]) == PR_TICKS - 20'h00001)
    else $error("phase reversal trip time wrong");
  pr_block_a: assert property (run_blk_c |=> st_r[PR] == ST_IDLE)
    else $error("phase reversal active while running");
  ov_block_a: assert property (ov_block_i[1] |=> st_r[OV+1] == ST_IDLE)
    else $error("blocked overvoltage stage active");
  ov_group_a: assert property (st_r[OV+1] == ST_TIMING && tick_r && !off_c[OV+1] &&
    20'(cnt_r[OV+1] + 20'h00001) >= 20'(ov_cfg_i[ov_group_i][1].dly) |=>
    st_r[OV+1] == ST_TRIPPED)
    else $error("wrong setting group delay");
  tick_gap_a: assert property (tick_r |=> !tick_r [*2])
    else $error("timebase tick too frequent");
endmodule

// File: phasor_source.sv
// Purpose: front-end model, sequence amplitudes in, phase phasors out
// Assumes: positive sequence on phase a at zero angle
// Notes: sqrt(3)/2 approximated as 887/1024
module phasor_source (
  input wire logic signed [15:0] pos_i,
  input wire logic signed [15:0] neg_i,
  output nsp_pkg::tri_t tri_o
);
  import nsp_pkg::*;
  logic signed [31:0] sum;
  logic signed [31:0] dif;
  ////////////////////////////////////////////////////////////////////////////////
  // Phase b is pos*a^2 + neg*a, phase c is pos*a + neg*a^2
  always_comb begin
    sum = 32'(pos_i) + 32'(neg_i);
    dif = ((32'(neg_i) - 32'(pos_i)) * 887) >>> 10;
    tri_o.a.re = 16'(sum);
    tri_o.a.im = 16'h0000;
    tri_o.b.re = 16'(-(sum >>> 1));
    tri_o.b.im = 16'(dif);
    tri_o.c.re = 16'(-(sum >>> 1));
    tri_o.c.im = 16'(-dif);
  end
endmodule

// File: negative_sequence_protection_test.sv
// Purpose: self-checking bench for the negative-sequence protection block
// Assumes: 10-cycle timebase tick, rated current and nominal voltage 1000 LSB
// Notes: trip times are accepted from one tick early to 12 cycles late
module negative_sequence_protection_test;
  timeunit 1ns;
  timeprecision 1ps;
  import nsp_pkg::*;
  typedef struct {int ip; int ineg; int vn; int grp; int blk; logic [5:0] exp;} row_t;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic signed [15:0] ipos = 16'sh03E8;
  logic signed [15:0] ineg = 16'sh0000;
  logic signed [15:0] vneg = 16'sh0000;
  logic signed [15:0] vpos = 16'sh03E8;
  tri_t cur;
  tri_t vol;
  logic [12:0] bc_dly = 13'h000A;
  logic [6:0] bc_pct = 7'h0A;
  logic [6:0] oc_pct = 7'h05;
  logic [12:0] oc_dly = 13'h000A;
  oc_mode_t oc_mode = OC_DEFINITE;
  logic [5:0] mult = 6'h01;
  logic run = 1'b0;
  ov_set_t [3:0][2:0] cfg;
  logic [1:0] grp = 2'h0;
  logic [2:0] blk = 3'h0;
  stage_out_t bc;
  stage_out_t oc;
  stage_out_t pr;
  stage_out_t [2:0] ov;
  logic [5:0] st;
  logic [5:0] tr;
  int num_errors = 0;
  int comparisons = 0;
  int cyc_n = 0;
  int t0 = 0;
  row_t rows[9];
  ////////////////////////////////////////////////////////////////////////////////
  phasor_source cur_src (.pos_i(ipos), .neg_i(ineg), .tri_o(cur));
  phasor_source vol_src (.pos_i(vpos), .neg_i(vneg), .tri_o(vol));
  negative_sequence_protection #(.TICK_CYCLES(10), .I_LSB_UA(1000)) dut (
    .clk_i(clk), .nrst_i(nrst), .cur_i(cur), .vol_i(vol),
    .motor_rated_current_i(16'h03E8), .nominal_voltage_i(16'h03E8),
    .bc_pct_i(bc_pct), .bc_dly_i(bc_dly), .oc_pct_i(oc_pct), .oc_mode_i(oc_mode),
    .oc_dly_i(oc_dly), .delay_multiplier_i(mult), .motor_running_i(run),
    .ov_cfg_i(cfg), .ov_group_i(grp), .ov_block_i(blk),
    .bc_o(bc), .oc_o(oc), .pr_o(pr), .ov_o(ov)
  );
  assign st = {ov[2].start, ov[1].start, ov[0].start, pr.start, oc.start, bc.start};
  assign tr = {ov[2].trip, ov[1].trip, ov[0].trip, pr.trip, oc.trip, bc.trip};
  always #2 clk = ~clk;
  always @(posedge clk) cyc_n <= cyc_n + 1;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (num_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic put(input int ip, input int in_n, input int vn);
    @(posedge clk);
    ipos <= 16'(ip);
    ineg <= 16'(in_n);
    vneg <= 16'(vn);
    t0 = cyc_n;
  endtask
  // Trip of output bit b expected from one tick before to 12 cycles after the given count
  task automatic measure(input int b, input int ticks);
    int lo;
    int hi;
    lo = (ticks - 1) * 10;
    hi = ticks * 10 + 12;
    while (tr[b] !== 1'b1 && cyc_n - t0 <= hi) @(posedge clk);
    #1;
    check(32'(tr[b] === 1'b1 && cyc_n - t0 >= lo && cyc_n - t0 <= hi), 32'h1);
    if (tr[b] !== 1'b1) report_and_stop();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    for (int g = 0; g < 4; g++) begin
      for (int s = 0; s < 3; s++) begin
        cfg[g][s].pct = 7'(5 * (s + 1) + 20 * g);
        cfg[g][s].dly = 15'(8 + s);
      end
    end
    rows = '{'{1000, 0, 0, 0, 0, 6'h00}, '{1000, 70, 0, 0, 0, 6'h02},
      '{1000, 95, 0, 0, 0, 6'h02}, '{1000, 150, 120, 0, 0, 6'h1B},
      '{200, 60, 120, 2, 0, 6'h01}, '{300, 900, 520, 2, 0, 6'h1F},
      '{1000, 0, 520, 2, 2, 6'h08}, '{1000, 0, 290, 1, 0, 6'h08},
      '{1000, 0, 720, 3, 0, 6'h18}};
    cyc(8);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      put(1000, 0, 0);
      cyc(3);
      put(rows[i].ip, rows[i].ineg, rows[i].vn);
      grp <= 2'(rows[i].grp);
      blk <= 3'(rows[i].blk);
      cyc(3);
      #1;
      check(32'(st), 32'(rows[i].exp));
      check(32'(tr), 32'h0);
    end
    put(1000, 0, 0);
    grp <= 2'h0;
    blk <= 3'h0;
    cyc(3);
    put(1000, 0, 200);
    for (int s = 0; s < 3; s++) measure(3 + s, 8 + s);
    put(1000, 0, 49);
    cyc(3);
    #1;
    check(32'({ov[0], ov[1], ov[2]}), 32'h30);
    put(1000, 0, 45);
    cyc(2);
    #1;
    check(32'(ov), 32'h0);
    put(1000, 0, 200);
    cyc(3);
    blk <= 3'h1;
    cyc(2);
    #1;
    check(32'(st[5:3]), 32'h6);
    @(posedge clk);
    grp <= 2'h3;
    cyc(2);
    #1;
    check(32'(st[5:3]), 32'h0);
    put(1000, 0, 0);
    grp <= 2'h0;
    blk <= 3'h0;
    bc_dly <= 13'h000C;
    oc_dly <= 13'h000B;
    cyc(3);
    put(1000, 150, 0);
    measure(1, 110);
    measure(0, 120);
    put(1000, 0, 0);
    cyc(2);
    #1;
    check(32'({bc, oc}), 32'h0);
    // Raised thresholds keep a 15 percent unbalance quiet
    @(posedge clk);
    bc_pct <= 7'h14;
    oc_pct <= 7'h10;
    put(1000, 150, 0);
    cyc(3);
    #1;
    check(32'(st[1:0]), 32'h0);
    put(1000, 0, 0);
    bc_pct <= 7'h0A;
    oc_pct <= 7'h05;
    // Dependent time: multiplier over (1.0 squared minus 0.05 squared)
    for (int m = 1; m < 4; m += 2) begin
      @(posedge clk);
      mult <= 6'(m);
      oc_mode <= OC_DEPENDENT;
      cyc(3);
      put(1000, 1000, 0);
      measure(1, (m * 1000000 + 9974) / 9975);
      put(1000, 0, 0);
    end
    @(posedge clk);
    oc_mode <= OC_DEFINITE;
    cyc(3);
    put(300, 900, 0);
    measure(2, 10);
    @(posedge clk);
    run <= 1'b1;
    cyc(1900);
    #1;
    check(32'(pr), 32'h3);
    cyc(130);
    #1;
    check(32'(pr), 32'h0);
    put(300, 900, 200);
    cyc(3);
    nrst <= 1'b0;
    cyc(2);
    #1;
    check(32'({st, tr}), 32'h0);
    @(posedge clk);
    nrst <= 1'b1;
    cyc(3);
    #1;
    check(32'({st, tr}), 32'hFC0);
    report_and_stop();
  end
endmodule
